// ### design/usc_map.svh
// Purpose: Offsets, field positions and reset values for the serial element select logic
// Assumes: Register offsets are three-bit indexes on the register-select pins
// Notes:   Included by the top module; definitions only
//
// Summary of operation
// - Strobe low passes selects straight through
// - Strobe rising edge latches selects while high
// - Baud output is the 16x transmit clock
// - Baud rate equals reference over sixteen times divisor
// - Selected only when a, b high, c low
// - Status bit 4 shows clear-to-send level
// - Status bit 0 flags clear-to-send change
// - Change interrupts only if enabled, not auto
// - Auto mode lets clear-to-send gate transmitter
// - Eight-bit data bus driven only on reads
`ifndef USC_MAP_SVH
`define USC_MAP_SVH

`define USC_OFS_DIV_LO   3'h0
`define USC_OFS_DIV_HI   3'h1
`define USC_OFS_IER      3'h1
`define USC_OFS_LCR      3'h3
`define USC_OFS_MCR      3'h4
`define USC_OFS_MSR      3'h6

`define USC_IER_MS_BIT   3
`define USC_LCR_DLAB_BIT 7
`define USC_MCR_AUTO_BIT 5
`define USC_MSR_DCTS_BIT 0
`define USC_MSR_CTS_BIT  4

`define USC_REG_RST      8'h00
`define USC_DIV_LO_RST   8'h01
`define USC_DIV_HI_RST   8'h00
`define USC_SEL_RST      6'h00

`endif

// ### design/usc_pkg.sv
// Purpose: Shared types of the serial element select and modem status logic
// Assumes: Byte-wide host bus and a sixteen-bit baud divisor
// Notes:   Constants live in usc_map.svh
package usc_pkg;
  typedef logic [2:0]  usc_addr_t;
  typedef logic [7:0]  usc_byte_t;
  typedef logic [15:0] usc_div_t;
  typedef struct packed {
    logic      cs_a;
    logic      cs_b;
    logic      cs_c_n;
    usc_addr_t addr;
  } usc_sel_t;
endpackage

// ### design/usc_baud_if.sv
// Purpose: Carries divisor, tick and baud clock between top and divider
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/1ns
interface usc_baud_if;
  usc_pkg::usc_div_t divisor;
  logic              tick;
  logic              baud_out;
  modport gen  (input divisor, output tick, output baud_out);
  modport user (output divisor, input tick, input baud_out);
endinterface

// ### design/usc_baud_div.sv
// Purpose: Divides the reference clock by the programmed divisor
// Assumes: Reference oscillator is the system clock
// Notes:   Divisor zero stops the output low
`timescale 1ns/1ns
module usc_baud_div #(
  parameter int DIV_W = 16
) (
  input  wire logic   clk,
  input  wire logic   rst,
  usc_baud_if.gen     bif
);
  import usc_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [DIV_W-1:0] half;
  logic             wrap;
  logic             stopped;

  assign stopped    = (bif.divisor == '0);
  // Compare with >= so a divisor cut below the count still wraps at once
  assign wrap       = (count >= bif.divisor - 1'b1);
  assign next_count = (stopped || wrap) ? '0 : count + 1'b1;
  // High for the first ceil(N/2) cycles; divisor one gives a steady high
  assign half       = (bif.divisor >> 1) + {{(DIV_W-1){1'b0}}, bif.divisor[0]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count        <= '0;
      bif.tick     <= 1'b0;
      bif.baud_out <= 1'b0;
    end else begin
      count        <= next_count;
      bif.tick     <= !stopped && wrap;
      bif.baud_out <= !stopped && (next_count < half);
    end
  end
endmodule

// ### design/usc_top.sv
// Purpose: Host select, data bus, baud output and clear-to-send status of a serial element
// Assumes: All pins synchronous to clk; rd_en and wr_en are one-cycle requests
// Notes:   Only the divisor, interrupt enable, control and modem status registers live here
`timescale 1ns/1ns
`include "usc_map.svh"
module usc_top (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              addr_strobe_n,
  input  wire logic              reg_sel_0,
  input  wire logic              reg_sel_1,
  input  wire logic              reg_sel_2,
  input  wire logic              chip_sel_a,
  input  wire logic              chip_sel_b,
  input  wire logic              chip_sel_c_n,
  input  wire logic              rd_en,
  input  wire logic              wr_en,
  input  wire usc_pkg::usc_byte_t data_in,
  output usc_pkg::usc_byte_t     data_out,
  output logic                   data_oe,
  input  wire logic              cts_n,
  output logic                   baud_clk_x16_out,
  output logic                   baud_tick,
  output logic                   tx_permit,
  output logic                   modem_irq
);
  import usc_pkg::*;

  usc_sel_t  live_sel;
  usc_sel_t  held_sel;
  usc_sel_t  eff_sel;
  logic      selected;
  logic      rd_hit;
  logic      wr_hit;
  usc_byte_t ier;
  usc_byte_t lcr;
  usc_byte_t mcr;
  usc_byte_t div_lo;
  usc_byte_t div_hi;
  logic      dlab;
  logic      auto_cts;
  logic      ms_int_en;
  logic      wr_div_lo;
  logic      wr_div_hi;
  logic      wr_ier;
  logic      wr_lcr;
  logic      wr_mcr;
  logic      msr_rd;
  logic      cts_prev;
  logic      cts_change;
  logic      delta_cts;
  logic      next_delta_cts;
  usc_byte_t msr_val;
  usc_byte_t rd_mux;

  usc_baud_if bif ();

  usc_baud_div #(
    .DIV_W (16)
  ) u_baud (
    .clk (clk),
    .rst (rst),
    .bif (bif)
  );

  // Select path
  assign live_sel = {chip_sel_a, chip_sel_b, chip_sel_c_n, reg_sel_2, reg_sel_1, reg_sel_0};

  // Holds the last level seen while the strobe was low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_sel <= `USC_SEL_RST;
    end else if (!addr_strobe_n) begin
      held_sel <= live_sel;
    end
  end

  assign eff_sel  = addr_strobe_n ? held_sel : live_sel;
  assign selected = eff_sel.cs_a && eff_sel.cs_b && !eff_sel.cs_c_n;
  assign rd_hit   = selected && rd_en;
  // A read wins when a host asserts both strobes at once
  assign wr_hit   = selected && wr_en && !rd_en;

  // Register decode
  assign dlab      = lcr[`USC_LCR_DLAB_BIT];
  assign auto_cts  = mcr[`USC_MCR_AUTO_BIT];
  assign ms_int_en = ier[`USC_IER_MS_BIT];
  assign wr_div_lo = wr_hit && dlab && (eff_sel.addr == `USC_OFS_DIV_LO);
  assign wr_div_hi = wr_hit && dlab && (eff_sel.addr == `USC_OFS_DIV_HI);
  assign wr_ier    = wr_hit && !dlab && (eff_sel.addr == `USC_OFS_IER);
  assign wr_lcr    = wr_hit && (eff_sel.addr == `USC_OFS_LCR);
  assign wr_mcr    = wr_hit && (eff_sel.addr == `USC_OFS_MCR);
  assign msr_rd    = rd_hit && (eff_sel.addr == `USC_OFS_MSR);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_lo <= `USC_DIV_LO_RST;
      div_hi <= `USC_DIV_HI_RST;
    end else begin
      if (wr_div_lo) begin
        div_lo <= data_in;
      end
      if (wr_div_hi) begin
        div_hi <= data_in;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ier <= `USC_REG_RST;
      lcr <= `USC_REG_RST;
      mcr <= `USC_REG_RST;
    end else begin
      if (wr_ier) begin
        ier <= data_in;
      end
      if (wr_lcr) begin
        lcr <= data_in;
      end
      if (wr_mcr) begin
        mcr <= data_in;
      end
    end
  end

  assign bif.divisor = {div_hi, div_lo};

  // Clear-to-send tracking
  assign cts_change     = (cts_n != cts_prev);
  // A change in the read cycle keeps the flag so it is not lost
  assign next_delta_cts = cts_change || (delta_cts && !msr_rd);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cts_prev  <= 1'b1;
      delta_cts <= 1'b0;
    end else begin
      cts_prev  <= cts_n;
      delta_cts <= next_delta_cts;
    end
  end

  assign msr_val = usc_byte_t'({!cts_n, 3'h0, delta_cts});

  assign rd_mux =
    (eff_sel.addr == `USC_OFS_DIV_LO && dlab)  ? div_lo :
    (eff_sel.addr == `USC_OFS_DIV_HI && dlab)  ? div_hi :
    (eff_sel.addr == `USC_OFS_IER)             ? ier    :
    (eff_sel.addr == `USC_OFS_LCR)             ? lcr    :
    (eff_sel.addr == `USC_OFS_MCR)             ? mcr    :
    (eff_sel.addr == `USC_OFS_MSR)             ? msr_val : 8'h00;

  // Bus drive and modem side outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_out <= rd_hit ? rd_mux : 8'h00;
      data_oe  <= rd_hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_irq <= 1'b0;
      tx_permit <= 1'b1;
    end else begin
      modem_irq <= next_delta_cts && ms_int_en && !auto_cts;
      // Outside auto mode the transmitter is never held off here
      tx_permit <= !auto_cts || !cts_n;
    end
  end

  assign baud_clk_x16_out = bif.baud_out;
  assign baud_tick        = bif.tick;

  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_transparent;
    (!addr_strobe_n && chip_sel_a && chip_sel_b && !chip_sel_c_n && rd_en) |=> data_oe;
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("Live select read not answered");

  property p_latch_edge;
    ($past(!addr_strobe_n) && addr_strobe_n) |-> held_sel == $past(live_sel);
  endproperty
  a_latch_edge: assert property (p_latch_edge)
    else $error("Select not latched at strobe rise");

  property p_latch_hold;
    (addr_strobe_n && $past(addr_strobe_n)) |-> $stable(held_sel) && eff_sel == held_sel;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("Latched select moved while high");

  property p_deselect;
    (rd_en && !(eff_sel.cs_a && eff_sel.cs_b && !eff_sel.cs_c_n)) |=> !data_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("Bus driven while not selected");

  property p_drive_only_read;
    data_oe |-> $past(rd_en) && $past(selected);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read)
    else $error("Bus driven without read");

  property p_cts_level;
    msr_rd |=> data_out[`USC_MSR_CTS_BIT] == !$past(cts_n);
  endproperty
  a_cts_level: assert property (p_cts_level) else $error("Status bit 4 wrong");

  property p_cts_change;
    (cts_n != $past(cts_n))
      |=> delta_cts ##1 (!$past(msr_rd) || data_out[`USC_MSR_DCTS_BIT]);
  endproperty
  a_cts_change: assert property (p_cts_change) else $error("Change flag not set");

  property p_read_clears;
    (msr_rd && cts_n == $past(cts_n)) |=> !delta_cts;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("Change flag not cleared by read");

  property p_irq;
    (next_delta_cts && ms_int_en && !auto_cts) |=> modem_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Modem interrupt missing");

  property p_irq_auto;
    auto_cts |=> !modem_irq;
  endproperty
  a_irq_auto: assert property (p_irq_auto) else $error("Interrupt raised in auto mode");

  property p_hold_off;
    (auto_cts && cts_n) |=> !tx_permit ##2 ($past(auto_cts) || tx_permit);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("Transmitter not held off");

  property p_baud_period;
    (baud_tick && bif.divisor == 16'h0004 && $stable(bif.divisor))
      |=> (!baud_tick && baud_clk_x16_out) ##1 (!baud_tick && !baud_clk_x16_out) [*2]
      ##1 baud_tick;
  endproperty
  a_baud_period: assert property (p_baud_period) else $error("Baud period wrong");

  property p_live_deselect;
    (!addr_strobe_n && !chip_sel_a) |-> !selected;
  endproperty
  a_live_deselect: assert property (p_live_deselect) else $error("Live select ignored");

  property p_lcr_write;
    wr_lcr |=> lcr == $past(data_in);
  endproperty
  a_lcr_write: assert property (p_lcr_write) else $error("Control write lost");

  property p_div_write;
    wr_div_lo |=> bif.divisor[7:0] == $past(data_in);
  endproperty
  a_div_write: assert property (p_div_write) else $error("Divisor write lost");

  property p_tick_pulse;
    (baud_tick && bif.divisor > 16'h0001 && $stable(bif.divisor)) |=> !baud_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("Tick longer than one cycle");

  property p_tick_high;
    baud_tick |-> baud_clk_x16_out;
  endproperty
  a_tick_high: assert property (p_tick_high) else $error("Tick without baud rise");

  property p_data_idle;
    !data_oe |-> data_out == 8'h00;
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("Data out while idle");

  property p_irq_masked;
    !ms_int_en |=> !modem_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("Masked interrupt raised");

  property p_irq_clear;
    (msr_rd && !cts_change) |=> !modem_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("Interrupt kept after read");

  property p_permit_manual;
    !auto_cts |=> tx_permit;
  endproperty
  a_permit_manual: assert property (p_permit_manual) else $error("Held off, not auto");

  property p_permit_release;
    (auto_cts && !cts_n) |=> tx_permit;
  endproperty
  a_permit_release: assert property (p_permit_release)
    else $error("Transmitter not released");

  c_latched_read: cover property ($rose(addr_strobe_n) ##[1:8] (addr_strobe_n && rd_hit));
  c_change_read:  cover property (delta_cts && msr_rd);
  c_irq:          cover property ($rose(modem_irq));
  c_held_off:     cover property ($fell(tx_permit));
  c_div_write:    cover property (wr_div_lo);
endmodule

// ### verification/usc_modem.sv
// Purpose: Modem model that drives the clear-to-send line
// Assumes: Level changes launched just after a rising clock edge
// Notes:   Line is inactive high until the bench asks for clear-to-send
`timescale 1ns/1ns
module usc_modem (
  input  wire logic clk,
  input  wire logic cts_on,
  output logic      cts_n
);
  initial cts_n = 1'b1;
  // Active low sense; launched off the edge so the device never sees a race
  always @(posedge clk) begin
    cts_n <= #1 !cts_on;
  end
endmodule

// ### verification/usc_top_tb_top.sv
// Purpose: Self-checking bench for select latch, baud output and clear-to-send status
// Assumes: Host holds the strobe low unless a scenario tests the latch
// Notes:   Clock doubles as the baud reference
`timescale 1ns/1ns
module usc_top_tb_top;
  import usc_pkg::*;
  logic      clk = 1'b0, rst = 1'b1, strobe_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
  logic      cs_a = 1'b1, cs_b = 1'b1, cs_c_n = 1'b0, cts_on = 1'b0;
  usc_addr_t sel = 3'h0;
  usc_byte_t din = 8'h00, dout;
  logic      oe, cts_n, baud, tick, permit, irq;
  logic      rcv_clk;
  int        errors = 0, compares = 0, cycles = 0, n_tick, n_high;

  usc_top dut (.clk(clk), .rst(rst), .addr_strobe_n(strobe_n), .reg_sel_0(sel[0]),
    .reg_sel_1(sel[1]), .reg_sel_2(sel[2]), .chip_sel_a(cs_a), .chip_sel_b(cs_b),
    .chip_sel_c_n(cs_c_n), .rd_en(rd_en), .wr_en(wr_en), .data_in(din),
    .data_out(dout), .data_oe(oe), .cts_n(cts_n), .baud_clk_x16_out(baud),
    .baud_tick(tick), .tx_permit(permit), .modem_irq(irq));
  usc_modem modem (.clk(clk), .cts_on(cts_on), .cts_n(cts_n));
  // Board ties the baud output to the receiver clock input
  assign rcv_clk = baud;

  always #4 clk = ~clk;

  task automatic wrap_up();
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input usc_byte_t got, input usc_byte_t exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input usc_addr_t a, input usc_byte_t d);
    sel = a;
    din = d;
    wr_en = 1'b1;
    step(1);
    wr_en = 1'b0;
    step(1);
  endtask

  // Expects an answer only when the effective select is valid
  task automatic rd(input usc_addr_t a, input logic sel_ok, input usc_byte_t exp);
    sel = a;
    rd_en = 1'b1;
    step(1);
    rd_en = 1'b0;
    chk1(oe, sel_ok);
    if (sel_ok) chk(dout, exp);
    step(1);
    chk1(oe, 1'b0);
  endtask

  task automatic t_chip_select();
    logic [2:0] bad [3] = '{3'b010, 3'b100, 3'b111};
    foreach (bad[i]) begin
      {cs_a, cs_b, cs_c_n} = bad[i];
      rd(3'h6, 1'b0, 8'h00);
    end
    {cs_a, cs_b, cs_c_n} = 3'b110;
    rd(3'h6, 1'b1, 8'h00);
  endtask

  task automatic t_strobe_latch();
    wr(3'h1, 8'h05);
    // Live index 0 reads zero, so only the latched index gives this value
    sel = 3'h1;
    step(1);
    strobe_n = 1'b1;
    cs_a = 1'b0;
    rd(3'h0, 1'b1, 8'h05);
    strobe_n = 1'b0;
    rd(3'h0, 1'b0, 8'h00);
    cs_a = 1'b1;
  endtask

  task automatic t_baud();
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h00);
    n_tick = 0;
    n_high = 0;
    repeat (40) begin
      step(1);
      n_tick += (tick === 1'b1);
      n_high += (rcv_clk === 1'b1);
    end
    chk(n_tick[7:0], 8'h0A);
    chk(n_high[7:0], 8'h14);
  endtask

  task automatic t_cts();
    wr(3'h1, 8'h08);
    cts_on = 1'b1;
    step(3);
    chk1(irq, 1'b1);
    rd(3'h6, 1'b1, 8'h11);
    chk1(irq, 1'b0);
    rd(3'h6, 1'b1, 8'h10);
  endtask

  task automatic t_auto();
    wr(3'h4, 8'h20);
    cts_on = 1'b0;
    step(3);
    chk1(permit, 1'b0);
    chk1(irq, 1'b0);
    rd(3'h6, 1'b1, 8'h01);
    cts_on = 1'b1;
    step(3);
    chk1(permit, 1'b1);
  endtask

  initial begin
    // Strobe held low so selects stay transparent by default
    step(5);
    rst = 1'b0;
    chk1(oe, 1'b0);
    chk1(permit, 1'b1);
    chk1(irq, 1'b0);
    t_chip_select();
    t_strobe_latch();
    t_baud();
    t_cts();
    t_auto();
    wrap_up();
  end
endmodule
